// [common/scd_defines.vh]
// offsets, field positions, reset values and codes of the config/debug bank
`ifndef SCD_DEFINES_VH
`define SCD_DEFINES_VH

`define SCD_OFS_PHY4 8'h94
`define SCD_OFS_OPMODE 8'h98
`define SCD_OFS_DBGCTL 8'h9c
`define SCD_OFS_DBGDATA 8'hac
`define SCD_OFS_SSCAP 8'hb0
`define SCD_OFS_SSID 8'hb4

`define SCD_TX_MARGIN_RST 16'h116b
`define SCD_RXEQ_UP_RST 8'h86
`define SCD_RXEQ_DN_RST 8'h00
`define SCD_OPMODE_RST 16'h0122
`define SCD_CLKEN_RST 4'hf
`define SCD_CAP_ID 8'h0d
`define SCD_NEXT_PTR_RST 8'hc0

`define SCD_CTL_PORT_LSB 0
`define SCD_CTL_TRIG_LSB 2
`define SCD_CTL_CLEAR_BIT 6
`define SCD_CLK_PD_BIT 20

`define SCD_TRIG_DETECT 4'h1
`define SCD_TRIG_POLLING 4'h2
`define SCD_TRIG_CONFIG 4'h3
`define SCD_TRIG_L0 4'h4
`define SCD_TRIG_L0S 4'h5
`define SCD_TRIG_L1 4'h6
`define SCD_TRIG_L2 4'h7
`define SCD_TRIG_DISABLE 4'h8
`define SCD_TRIG_HOT_RESET 4'h9
`define SCD_TRIG_LOOPBACK 4'ha
`define SCD_TRIG_RECOVERY 4'hb

`define SCD_BUF_DEPTH 16
`define SCD_BUF_AW 4

`endif

// [logic/scd_debug_mem.v]
// small debug capture memory with registered read data
`timescale 1ns/1ps
`include "scd_defines.vh"

module scd_debug_mem (
    ref_clk, // core clock
    we, // write strobe
    waddr, // write address
    wdata, // write word
    raddr, // read address
    rdata // registered read word
);
    input wire ref_clk;
    input wire we;
    input wire [`SCD_BUF_AW-1:0] waddr;
    input wire [31:0] wdata;
    input wire [`SCD_BUF_AW-1:0] raddr;
    output reg [31:0] rdata;

    reg [31:0] mem [0:`SCD_BUF_DEPTH-1];

    // write port and registered read port
    always @(posedge ref_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // scd_debug_mem

// [logic/scd_config_debug.v]
// per-port configuration and debug register bank of the switch
`timescale 1ns/1ps
`include "scd_defines.vh"

module scd_config_debug (
    ref_clk, // core clock, 10 MHz
    rst, // synchronous reset, active high
    is_upstream, // strap: this is the upstream port
    refclk_buffer_powerdown_strap, // strap pin sampled at reset
    op_mode_straps, // {pending,scan,pkg[1:0],phy,dbg,fast,iddq_n,rom_skip}
    cfg_wr, // config write strobe
    cfg_rd, // config read strobe
    cfg_addr, // config byte address
    cfg_wdata, // config write data
    cfg_rdata, // config read data
    sb_wr, // sideband (smbus / eeprom load) write strobe
    sb_rd, // sideband read strobe
    sb_addr, // sideband byte address
    sb_wdata, // sideband write data
    sb_rdata, // sideband read data
    ltssm_state, // current link state code
    dbg_valid, // debug sample valid
    dbg_word, // debug sample
    debug_port_select, // selected debug port
    refclk_out_en // per-pair reference clock output enable
);
    input wire ref_clk;
    input wire rst;
    input wire is_upstream;
    input wire refclk_buffer_powerdown_strap;
    input wire [8:0] op_mode_straps;
    input wire cfg_wr;
    input wire cfg_rd;
    input wire [7:0] cfg_addr;
    input wire [31:0] cfg_wdata;
    output reg [31:0] cfg_rdata;
    input wire sb_wr;
    input wire sb_rd;
    input wire [7:0] sb_addr;
    input wire [31:0] sb_wdata;
    output reg [31:0] sb_rdata;
    input wire [3:0] ltssm_state;
    input wire dbg_valid;
    input wire [31:0] dbg_word;
    output wire [1:0] debug_port_select;
    output wire [3:0] refclk_out_en;

    // --------------------------------------------------------------
    // register state
    // --------------------------------------------------------------
    reg [7:0] rxeq_q;
    reg [15:0] opmode_q;
    reg [4:0] clkbuf_q;
    reg [6:0] dbgctl_q;
    reg [31:0] ssid_q;
    reg [7:0] next_ptr_q;
    reg reset_seen_q;
    reg armed_q;
    reg [`SCD_BUF_AW:0] wr_ptr_q;
    reg [`SCD_BUF_AW:0] rd_ptr_q;
    reg [31:0] rd_word;
    reg [31:0] cfg_d;
    reg [31:0] sb_d;
    wire [31:0] mem_rdata;
    wire trig_hit;
    wire buf_full;
    wire buf_empty;
    wire buf_we;
    wire clear_now;
    wire sb_pop;
    wire [`SCD_BUF_AW:0] rd_next;
    reg fwd_q;
    reg [31:0] fwd_word_q;
    wire [31:0] phy_img;
    wire [31:0] opm_img;
    wire [31:0] ctl_img;
    wire [31:0] cap_img;

    // trigger code match; 0100b is taken as L0
    function trig_match;
        input [3:0] sel;
        input [3:0] state;
        begin
            case (sel)
                `SCD_TRIG_DETECT, `SCD_TRIG_POLLING, `SCD_TRIG_CONFIG,
                `SCD_TRIG_L0, `SCD_TRIG_L0S, `SCD_TRIG_L1,
                `SCD_TRIG_L2, `SCD_TRIG_DISABLE, `SCD_TRIG_HOT_RESET,
                `SCD_TRIG_LOOPBACK, `SCD_TRIG_RECOVERY:
                    trig_match = (sel == state);
                default: trig_match = 1'b0; // reserved codes never fire
            endcase
        end
    endfunction

    // register images as both paths see them
    assign phy_img = {8'h00, rxeq_q, `SCD_TX_MARGIN_RST};
    assign opm_img = {11'h000, clkbuf_q, opmode_q};
    assign ctl_img = {25'h0000000, dbgctl_q};
    assign cap_img = {16'h0000, next_ptr_q, `SCD_CAP_ID};

    // common read mux for both access paths; every value comes in as an
    // argument so that the calling process sees each change
    function [31:0] reg_read;
        input [7:0] addr;
        input sideband;
        input [31:0] phy;
        input [31:0] opm;
        input [31:0] ctl;
        input [31:0] head;
        input [31:0] cap;
        input [31:0] ids;
        begin
            case (addr)
                `SCD_OFS_PHY4: reg_read = phy;
                `SCD_OFS_OPMODE: reg_read = opm;
                `SCD_OFS_DBGCTL: reg_read = ctl;
                `SCD_OFS_DBGDATA:
                    reg_read = sideband ? head : 32'h00000000;
                `SCD_OFS_SSCAP: reg_read = cap;
                `SCD_OFS_SSID: reg_read = ids;
                default: reg_read = 32'h00000000;
            endcase
        end
    endfunction

    // --------------------------------------------------------------
    // strap capture and loadable defaults
    // --------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (rst) begin
            rxeq_q <= `SCD_RXEQ_DN_RST;
            opmode_q <= `SCD_OPMODE_RST;
            clkbuf_q <= {1'b0, `SCD_CLKEN_RST};
            ssid_q <= 32'h00000000;
            next_ptr_q <= `SCD_NEXT_PTR_RST;
            reset_seen_q <= 1'b1;
        end else if (reset_seen_q) begin
            // first cycle after release: catch the straps
            reset_seen_q <= 1'b0;
            rxeq_q <= is_upstream ? `SCD_RXEQ_UP_RST
                                  : `SCD_RXEQ_DN_RST;
            opmode_q <= {7'h00, op_mode_straps};
            clkbuf_q <= {refclk_buffer_powerdown_strap, `SCD_CLKEN_RST};
        end else if (sb_wr) begin
            // sideband / eeprom loader may overwrite loadable fields
            if (sb_addr == `SCD_OFS_OPMODE) begin
                clkbuf_q <= sb_wdata[20:16];
            end
            if (sb_addr == `SCD_OFS_SSID) begin
                ssid_q <= sb_wdata;
            end
        end
    end

    // reference clock enables: global disable overrides per-pair bits
    assign refclk_out_en = clkbuf_q[`SCD_CLK_PD_BIT-16] ? 4'h0
                         : clkbuf_q[3:0];

    // --------------------------------------------------------------
    // debug control register, writable from both paths
    // --------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (rst) begin
            dbgctl_q <= 7'h00;
        end else if (sb_wr && sb_addr == `SCD_OFS_DBGCTL) begin
            dbgctl_q <= sb_wdata[6:0];
        end else if (cfg_wr && cfg_addr == `SCD_OFS_DBGCTL) begin
            dbgctl_q <= cfg_wdata[6:0];
        end
    end

    assign debug_port_select = dbgctl_q[1:0];
    assign clear_now = dbgctl_q[`SCD_CTL_CLEAR_BIT];

    // --------------------------------------------------------------
    // debug capture buffer
    // --------------------------------------------------------------
    assign trig_hit = trig_match(dbgctl_q[5:2], ltssm_state);
    assign buf_full = (wr_ptr_q[`SCD_BUF_AW] != rd_ptr_q[`SCD_BUF_AW]) &&
                      (wr_ptr_q[`SCD_BUF_AW-1:0] == rd_ptr_q[`SCD_BUF_AW-1:0]);
    assign buf_empty = (wr_ptr_q == rd_ptr_q);
    assign buf_we = dbg_valid && (armed_q || trig_hit) && !buf_full &&
                    !clear_now;
    assign sb_pop = sb_rd && sb_addr == `SCD_OFS_DBGDATA && !buf_empty;
    // read address runs one pop ahead so back-to-back pops see a fresh head
    assign rd_next = sb_pop ? rd_ptr_q + 5'h01 : rd_ptr_q;

    // arm on trigger, write pointer, read pointer; clear empties all
    always @(posedge ref_clk) begin
        if (rst || clear_now) begin
            armed_q <= 1'b0;
            wr_ptr_q <= 5'h00;
            rd_ptr_q <= 5'h00;
            fwd_q <= 1'b0;
        end else begin
            if (trig_hit) begin
                armed_q <= 1'b1;
            end
            if (buf_we) begin
                wr_ptr_q <= wr_ptr_q + 5'h01;
            end
            if (sb_pop) begin
                rd_ptr_q <= rd_ptr_q + 5'h01;
            end
            // a word landing where the memory reads next is not in rdata yet
            fwd_q <= buf_we && (wr_ptr_q == rd_next);
        end
    end

    // bypass copy of the last sample offered to the buffer
    always @(posedge ref_clk) begin
        fwd_word_q <= dbg_word;
    end

    scd_debug_mem u_mem (
        .ref_clk(ref_clk),
        .we(buf_we),
        .waddr(wr_ptr_q[`SCD_BUF_AW-1:0]),
        .wdata(dbg_word),
        .raddr(rd_next[`SCD_BUF_AW-1:0]),
        .rdata(mem_rdata)
    );

    // head word shown only while the buffer holds data; a word written one
    // cycle ago into the head slot comes from the bypass register
    always @* begin
        if (buf_empty) begin
            rd_word = 32'h00000000;
        end else if (fwd_q) begin
            rd_word = fwd_word_q;
        end else begin
            rd_word = mem_rdata;
        end
    end

    // --------------------------------------------------------------
    // registered read data for both paths
    // --------------------------------------------------------------
    always @* begin
        cfg_d = cfg_rd ? reg_read(cfg_addr, 1'b0, phy_img, opm_img, ctl_img,
                                  rd_word, cap_img, ssid_q) : cfg_rdata;
        sb_d = sb_rd ? reg_read(sb_addr, 1'b1, phy_img, opm_img, ctl_img,
                                rd_word, cap_img, ssid_q) : sb_rdata;
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            cfg_rdata <= 32'h00000000;
            sb_rdata <= 32'h00000000;
        end else begin
            cfg_rdata <= cfg_d;
            sb_rdata <= sb_d;
        end
    end
endmodule // scd_config_debug

// [verification/scd_checker.sv]
// port assertions of the config/debug bank
`timescale 1ns/1ps
module scd_checker (
    input wire ref_clk, // clock
    input wire rst, // reset
    input wire cfg_rd, // cfg read
    input wire [7:0] cfg_addr, // cfg address
    input wire [31:0] cfg_rdata, // cfg data
    input wire sb_wr, // sb write
    input wire sb_rd, // sb read
    input wire [7:0] sb_addr, // sb address
    input wire [31:0] sb_wdata, // sb wdata
    input wire [31:0] sb_rdata, // sb rdata
    input wire [3:0] refclk_out_en // pair enables
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // values held while in reset
    a_reset_clk_en: assert property (
        disable iff (1'b0) rst ##1 rst |-> refclk_out_en == 4'hf)
        else $error("enables wrong in reset");
    a_reset_rdata: assert property (
        disable iff (1'b0) rst ##1 rst |-> (cfg_rdata | sb_rdata) == 0)
        else $error("read data not zero in reset");
    // register reads and writes
    a_clk_gate: assert property (sb_wr && sb_addr == 8'h98 |=>
        refclk_out_en == ($past(sb_wdata[20]) ? 4'h0 : $past(sb_wdata[19:16])))
        else $error("clock pair enables wrong");
    a_opmode_zero: assert property (cfg_rd && cfg_addr == 8'h98 |=>
        cfg_rdata[31:21] == 0 && cfg_rdata[15:9] == 0)
        else $error("opmode zero bits set");
    a_cfg_hidden: assert property (cfg_rd && cfg_addr == 8'hac |=>
        cfg_rdata == 0) else $error("debug data seen by cfg");
    a_cap_header: assert property (cfg_rd &&
        cfg_addr == 8'hb0 |=> cfg_rdata == 32'h0000c00d)
        else $error("cap header wrong");
    a_clear_empties: assert property (sb_wr && sb_addr == 8'h9c &&
        sb_wdata[6] ##2 sb_rd && sb_addr == 8'hac |=> sb_rdata == 0)
        else $error("buffer not empty after clear");
    a_rdata_holds: assert property (!cfg_rd |=> $stable(cfg_rdata))
        else $error("cfg read data moved");
    c_pop: cover property (sb_rd && sb_addr == 8'hac ##1 sb_rdata != 0);
    c_gate: cover property (sb_wr && sb_addr == 8'h98 && sb_wdata[20]);
    c_hide: cover property (cfg_rd && cfg_addr == 8'hac);
    c_burst: cover property (sb_rd && sb_addr == 8'hac ##1
        sb_rd && sb_addr == 8'hac);
endmodule // scd_checker
bind scd_config_debug scd_checker u_chk (.ref_clk, .rst, .cfg_rd, .cfg_addr,
    .cfg_rdata, .sb_wr, .sb_rd, .sb_addr, .sb_wdata, .sb_rdata, .refclk_out_en);

// [verification/scd_host.sv]
// sideband management master driving the bank's sideband port
`timescale 1ns/1ps
module scd_host (
    input wire ref_clk, // clock
    output logic sb_wr, // write strobe
    output logic sb_rd, // read strobe
    output logic [7:0] sb_addr, // address
    output logic [31:0] sb_wdata, // write data
    input wire [31:0] sb_rdata // read data
);
    initial begin
        sb_wr = 0;
        sb_rd = 0;
        sb_addr = 0;
        sb_wdata = 0;
    end
    // one transfer after stall idle cycles; idle lines show inverted values
    task xfer(input bit wr, input [7:0] a, input [31:0] d, input int stall,
        output [31:0] q);
        repeat (stall) @(posedge ref_clk);
        @(posedge ref_clk);
        sb_wr <= wr;
        sb_rd <= !wr;
        sb_addr <= a;
        sb_wdata <= d;
        @(posedge ref_clk);
        sb_wr <= 0;
        sb_rd <= 0;
        sb_addr <= ~a;
        sb_wdata <= ~d;
        #1 q = sb_rdata;
    endtask
    // two debug data pops on back-to-back edges
    task pop2(output [31:0] q0, output [31:0] q1);
        @(posedge ref_clk);
        sb_wr <= 0;
        sb_rd <= 1;
        sb_addr <= 8'hac;
        @(posedge ref_clk);
        #1 q0 = sb_rdata;
        @(posedge ref_clk);
        sb_rd <= 0;
        sb_addr <= 8'h53;
        #1 q1 = sb_rdata;
    endtask
endmodule // scd_host

// [verification/testbench.sv]
// self-checking bench of the config/debug bank
`timescale 1ns/1ps
module testbench;
    logic ref_clk, rst, is_upstream, strap, cfg_wr, cfg_rd, dbg_valid;
    logic sb_wr, sb_rd;
    logic [8:0] straps;
    logic [7:0] cfg_addr, sb_addr;
    logic [31:0] cfg_wdata, cfg_rdata, sb_wdata, sb_rdata, dbg_word, q, w;
    logic [3:0] ltssm_state, refclk_out_en;
    logic [1:0] port_sel;
    logic [31:0] words [0:17];
    logic [31:0] dflt [0:5];
    logic [7:0] adr [0:5];
    logic [3:0] codes [0:10];
    int num_errors = 0, cmp_count = 0, cycles = 0;
    scd_config_debug dut (.ref_clk, .rst, .is_upstream,
        .refclk_buffer_powerdown_strap(strap), .op_mode_straps(straps),
        .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata, .sb_wr, .sb_rd,
        .sb_addr, .sb_wdata, .sb_rdata, .ltssm_state, .dbg_valid, .dbg_word,
        .debug_port_select(port_sel), .refclk_out_en);
    scd_host h (.ref_clk, .sb_wr, .sb_rd, .sb_addr, .sb_wdata, .sb_rdata);
    initial begin
        ref_clk = 0;
        forever #50 ref_clk = ~ref_clk;
    end
    task chk(input [31:0] got, input [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task cfg(input bit wr, input [7:0] a, input [31:0] d);
        @(posedge ref_clk);
        cfg_wr <= wr;
        cfg_rd <= !wr;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge ref_clk);
        cfg_wr <= 0;
        cfg_rd <= 0;
        cfg_addr <= ~a;
        cfg_wdata <= ~d;
        #1 q = cfg_rdata;
    endtask
    function [3:0] exp_en(input [4:0] f);
        exp_en = f[4] ? 4'h0 : f[3:0];
    endfunction
    task tally_and_finish;
        $display("TB: %0d compares, %0d errors", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // hang guard
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            tally_and_finish;
        end
    end
    initial begin
        {rst, is_upstream, strap, straps} = {3'h6, 9'h122};
        {cfg_wr, cfg_rd, cfg_addr, cfg_wdata, dbg_valid} = 0;
        {ltssm_state, dbg_word} = 0;
        adr = '{8'h94, 8'h98, 8'h9c, 8'hac, 8'hb0, 8'hb4};
        dflt = '{32'h0086116b, 32'h000f0122, 0, 0, 32'h0000c00d, 0};
        codes = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11};
        w = $urandom(32'hd07865f6);
        repeat (3) @(posedge ref_clk);
        rst <= 0;
        repeat (2) @(posedge ref_clk);
        // defaults and read-only places
        for (int i = 0; i < 6; i++) begin
            cfg(0, adr[i], 0);
            chk(q, dflt[i]);
        end
        chk(refclk_out_en, 4'hf);
        cfg(1, 8'hb4, 32'hffffffff);
        cfg(0, 8'hb4, 0);
        chk(q, 0);
        w = $urandom;
        h.xfer(1, 8'hb4, w, 1, q);
        cfg(0, 8'hb4, 0);
        chk(q, w);
        $display("TB: defaults and ids done");
        // clock buffer field through the sideband
        for (int i = 0; i < 6; i++) begin
            w = $urandom;
            w[20] = i[0];
            h.xfer(1, 8'h98, w, 0, q);
            cfg(0, 8'h98, 0);
            chk(refclk_out_en, exp_en(w[20:16]));
            chk(q, {11'h0, w[20:16], 16'h0122});
        end
        $display("TB: clock buffer done");
        // each trigger code, preceded by a word of a near state
        for (int i = 0; i < 11; i++) begin
            cfg(1, 8'h9c, 32'h40);
            cfg(1, 8'h9c, {26'h0, codes[i], 2'h0});
            @(posedge ref_clk);
            ltssm_state <= codes[i] ^ 4'h2;
            dbg_valid <= 1;
            dbg_word <= $urandom;
            w = $urandom;
            @(posedge ref_clk);
            ltssm_state <= codes[i];
            dbg_word <= w;
            @(posedge ref_clk);
            dbg_valid <= 0;
            cfg(0, 8'hac, 0);
            chk(q, 0);
            h.xfer(0, 8'hac, 0, i % 3, q);
            chk(q, w);
            h.xfer(0, 8'hac, 0, 0, q);
            chk(q, 0);
        end
        // a reserved trigger code never starts a capture
        cfg(1, 8'h9c, 32'h40);
        cfg(1, 8'h9c, 32'h30);
        @(posedge ref_clk);
        ltssm_state <= 4'hc;
        dbg_valid <= 1;
        dbg_word <= $urandom | 1;
        @(posedge ref_clk);
        dbg_valid <= 0;
        h.xfer(0, 8'hac, 0, 0, q);
        chk(q, 0);
        $display("TB: triggers done");
        // overfill the buffer, drain it, then clear a partial fill
        cfg(1, 8'h9c, 32'h2b);
        @(posedge ref_clk);
        ltssm_state <= 4'ha;
        dbg_valid <= 1;
        for (int i = 0; i < 18; i++) begin
            words[i] = $urandom;
            dbg_word <= words[i];
            @(posedge ref_clk);
        end
        dbg_valid <= 0;
        chk(port_sel, 2'h3);
        for (int i = 0; i < 16; i += 2) begin
            h.pop2(q, w);
            chk(q, words[i]);
            chk(w, words[i + 1]);
        end
        h.xfer(0, 8'hac, 0, 0, q);
        chk(q, 0);
        @(posedge ref_clk);
        dbg_valid <= 1;
        repeat (3) @(posedge ref_clk);
        dbg_valid <= 0;
        h.xfer(1, 8'h9c, 32'h68, 0, q);
        h.xfer(0, 8'hac, 0, 0, q);
        chk(q, 0);
        $display("TB: fill and clear done");
        // second reset as a downstream port with the buffer strap high
        @(posedge ref_clk);
        w = $urandom;
        rst <= 1;
        is_upstream <= 0;
        strap <= 1;
        straps <= w[8:0];
        repeat (3) @(posedge ref_clk);
        rst <= 0;
        repeat (2) @(posedge ref_clk);
        cfg(0, 8'h94, 0);
        chk(q, 32'h0000116b);
        cfg(0, 8'h98, 0);
        chk(q, {11'h0, 5'h1f, 7'h0, w[8:0]});
        chk(refclk_out_en, 4'h0);
        cfg(0, 8'hb4, 0);
        chk(q, 0);
        $display("TB: second reset done");
        tally_and_finish;
    end
endmodule // testbench
